// File: verilog/exec_unit_defs.svh
// constants of the micro-instruction execute unit
`ifndef EXEC_UNIT_DEFS_SVH
`define EXEC_UNIT_DEFS_SVH

// major opcodes, instr[15:12]
`define OP_MISC     4'h0
`define OP_LIT8     4'h8
`define OP_LIT24    4'h9
`define OP_TSHIFT   4'hA
`define OP_EXTRACT  4'hB
`define OP_BR_FWD   4'hC
`define OP_BR_BACK  4'hD
`define OP_CALL_FWD 4'hE
`define OP_CALL_REV 4'hF

// minor opcodes of the 0 group, instr[11:8]
`define SUB_SWAP    4'h2
`define SUB_CLEAR   4'h3
`define SUB_SHIFT1  4'h4
`define SUB_SHIFT2  4'h5
`define SUB_COUNT   4'h6

// destination codes of register row two
`define D_X         4'h0
`define D_Y         4'h1
`define D_T         4'h2
`define D_L         4'h3
`define D_A         4'h4
`define D_BR        4'h5
`define D_LR        4'h6
`define D_FA        4'h7
`define D_FB        4'h8
`define D_FL        4'h9
`define D_TAS       4'hA
`define D_CP        4'hB
`define D_MSM       4'hC
`define D_M         4'hD

// control pair fields
`define CPL_HI      4
`define CPL_LO      0
`define CPU_HI      6
`define CPU_LO      5

// sizes and steps
`define WORD_BITS   5'h18
`define ADDR_STEP   24'h000010
`define STACK_DEPTH 8
`define STACK_AW    3
`define REG_RESET   24'h000000

`endif

// File: verilog/exec_unit_pkg.sv
// types of the micro-instruction execute unit
package exec_unit_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LIT  = 2'b01,
    ST_SWAP = 2'b10
  } exec_state_t;

endpackage

// File: verilog/return_addr_stack.sv
// return address stack with registered top of stack
`timescale 1ns/100ps
`include "exec_unit_defs.svh"

module return_addr_stack (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // push a new entry or overwrite the top one
  input  wire logic        push,
  input  wire logic        load,
  input  wire logic [23:0] din,
  // top entry
  output logic      [23:0] top
);

  logic [23:0]           mem [`STACK_DEPTH];
  logic [`STACK_AW-1:0]  ptr;

  // storage; old entries are overwritten once depth wraps
  always_ff @(posedge clk)
  begin
    if (push)
      mem[ptr + 3'h1] <= din;
    else if (load)
      mem[ptr] <= din;
  end

  // pointer
  always_ff @(posedge clk)
  begin
    if (rst)
      ptr <= 3'h0;
    else if (push)
      ptr <= ptr + 3'h1;
  end

  // top copy held in a register so readers see no memory path
  always_ff @(posedge clk)
  begin
    if (rst)
      top <= `REG_RESET;
    else if (push || load)
      top <= din;
  end

endmodule // return_addr_stack

// File: verilog/microinstruction_execute_unit.sv
// execute unit for literal, shift, extract, branch, call, swap, clear and count
// How it works
// [RULE_01] field access adjusts address and length by variant
// [RULE_02] 8-bit literal loaded right-justified, zero filled
// [RULE_03] literal destinations limited to twelve row-two registers
// [RULE_04] maintenance store destination only in cassette mode
// [RULE_05] 24-bit literal, low 16 bits from next word
// [RULE_06] next word found at address plus 16
// [RULE_07] transform register shift/rotate left into destination
// [RULE_08] zero transform shift count uses container length
// [RULE_09] instruction register destination ORs into next instruction
// [RULE_10] condition and maintenance registers refused for shift
// [RULE_11] extract rotates, takes bits, right-justifies; 24 means 0
// [RULE_12] zero extract width uses container length
// [RULE_13] branches move by word displacement from next in-line
// [RULE_14] calls push next in-line address, then branch
// [RULE_15] pushed return address stored as bit address
// [RULE_16] swap exchanges field with register, zero fill, truncate
// [RULE_17] swap direction, length from instruction; zero uses container
// [RULE_18] clear zeroes registers whose flag bit is set
// [RULE_19] operand shift; zero count taken from container unit
// [RULE_20] single shifts fill zeros on vacated end
// [RULE_21] paired operands shift as one 48-bit value
// [RULE_22] field count adjusts address and length by literal
// [RULE_23] length underflow clamps at zero, others wrap
`timescale 1ns/100ps
`include "exec_unit_defs.svh"

module microinstruction_execute_unit (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // instruction stream from control memory
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  output logic             instr_ready,
  output logic      [23:0] fetch_addr,
  // second literal word
  input  wire logic        lit_valid,
  input  wire logic [15:0] lit_word,
  output logic      [23:0] lit_addr,
  // main memory swap port
  output logic             mem_req,
  output logic             mem_dir,
  output logic      [4:0]  mem_len,
  output logic      [23:0] mem_addr,
  output logic      [23:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [23:0] mem_rdata,
  // field access adjust request
  input  wire logic        fld_adj,
  input  wire logic [2:0]  fld_variant,
  input  wire logic [4:0]  fld_len,
  // operating mode and status
  input  wire logic        cassette_mode,
  output logic             dest_error,
  // modification of the next micro-instruction
  output logic             m_or_valid,
  output logic      [15:0] m_or_data,
  // register view
  output logic      [23:0] x,
  output logic      [23:0] y,
  output logic      [23:0] t,
  output logic      [23:0] l,
  output logic      [23:0] base_reg,
  output logic      [23:0] limit_reg,
  output logic      [23:0] field_addr_reg,
  output logic      [23:0] field_descriptor_b,
  output logic      [23:0] field_length_reg,
  output logic      [7:0]  control_reg_pair,
  output logic      [23:0] maintenance_store_reg,
  output logic      [23:0] return_stack_top
);

  exec_unit_pkg::exec_state_t state;
  logic        go;
  logic [3:0]  op;
  logic [3:0]  sub;
  logic [4:0]  container_length;
  logic [23:0] next_inline;
  logic [23:0] disp;
  logic        wr_en;
  logic [3:0]  wr_dest;
  logic [23:0] wr_val;
  logic        bad_dest;
  logic [3:0]  lit_dest;
  logic [7:0]  lit_hi;
  logic [1:0]  swap_sel;
  logic [4:0]  swap_len;
  logic        stk_push;
  logic        stk_load;
  logic [23:0] stk_din;

  function automatic logic [23:0] rotl24(input logic [23:0] v, input logic [4:0] n);
    logic [47:0] d;
    logic [4:0]  k;
    k = (n >= `WORD_BITS) ? n - `WORD_BITS : n;
    d = {v, v} << k;
    return d[47:24];
  endfunction

  function automatic logic [47:0] rotl48(input logic [47:0] v, input logic [5:0] n);
    logic [95:0] d;
    d = {v, v} << n;
    return d[95:48];
  endfunction

  function automatic logic [23:0] mask24(input logic [4:0] w);
    return (w >= `WORD_BITS) ? 24'hFFFFFF : 24'hFFFFFF >> (`WORD_BITS - w);
  endfunction

  // operand shift amount; unit code 10 is undefined and shifts nothing
  function automatic logic [5:0] xy_amt(input logic [4:0] n, input logic [1:0] unit);
    if (n != 5'h00)
      return {1'b0, n};
    case (unit)
      2'b00:   return 6'h01;
      2'b01:   return 6'h04;
      2'b11:   return 6'h08; // [RULE_19]
      default: return 6'h00;
    endcase
  endfunction

  // new {address, length}; only a falling length is clamped
  function automatic logic [47:0] field_count(input logic [23:0] fa_v, input logic [23:0] fl_v,
                                              input logic [2:0] v, input logic [4:0] n);
    logic [23:0] d;
    logic [23:0] fa_n;
    logic [23:0] fl_n;
    d    = {19'h00000, n};
    fa_n = fa_v;
    fl_n = fl_v;
    if (v == 3'b001 || v == 3'b011)
      fa_n = fa_v + d;
    if (v == 3'b100 || v == 3'b101 || v == 3'b111)
      fa_n = fa_v - d;
    if (v == 3'b010 || v == 3'b100)
      fl_n = fl_v + d;
    if (v == 3'b011 || v == 3'b110 || v == 3'b111)
      fl_n = (fl_v < d) ? `REG_RESET : fl_v - d; // [RULE_23]
    return {fa_n, fl_n};
  endfunction

  // decode
  assign op          = instr[15:12];
  assign sub         = instr[11:8];
  assign container_length         = control_reg_pair[`CPL_HI:`CPL_LO];
  assign instr_ready = (state == exec_unit_pkg::ST_IDLE);
  assign go          = instr_valid && instr_ready;
  assign next_inline = fetch_addr + `ADDR_STEP; // [RULE_06]
  assign lit_addr    = next_inline; // [RULE_06]
  assign disp        = {8'h00, instr[11:0], 4'h0};
  assign swap_len    = (instr[4:0] == 5'h00) ? container_length : instr[4:0]; // [RULE_17]

  // single-destination writes of literal, transform and extract operations
  always_comb
  begin
    wr_en    = 1'b0;
    wr_dest  = sub;
    wr_val   = `REG_RESET;
    bad_dest = 1'b0;
    if (state == exec_unit_pkg::ST_LIT && lit_valid)
    begin
      wr_en   = 1'b1;
      wr_dest = lit_dest;
      wr_val  = {lit_hi, lit_word}; // [RULE_05]
    end
    else if (go)
    begin
      case (op)
        `OP_LIT8, `OP_LIT24:
        begin
          bad_dest = (sub > `D_MSM) || (sub == `D_MSM && !cassette_mode); // [RULE_03] [RULE_04]
          wr_en    = !bad_dest && op == `OP_LIT8;
          wr_val   = {16'h0000, instr[7:0]}; // [RULE_02]
        end
        `OP_TSHIFT:
        begin
          bad_dest = (sub > `D_M) || (sub == `D_MSM); // [RULE_10]
          wr_en    = !bad_dest && sub != `D_M;
          if (instr[6])
            wr_val = rotl24(t, (instr[4:0] == 5'h00) ? container_length : instr[4:0]); // [RULE_07] [RULE_08]
          else
            wr_val = t << ((instr[4:0] == 5'h00) ? container_length : instr[4:0]); // [RULE_07] [RULE_08]
        end
        `OP_EXTRACT:
        begin
          wr_en   = 1'b1;
          wr_dest = {2'b00, instr[11:10]};
          wr_val  = (rotl24(t, instr[9:5]) >> (`WORD_BITS - ((instr[4:0] == 5'h00) ? container_length
                    : instr[4:0]))) & mask24((instr[4:0] == 5'h00) ? container_length : instr[4:0]); // [RULE_11] [RULE_12]
        end
        default:
          wr_en = 1'b0;
      endcase
    end
  end

  // sequencing: literal second word and memory swap wait here
  always_ff @(posedge clk)
  begin
    if (rst)
      state <= exec_unit_pkg::ST_IDLE;
    else
      case (state)
        exec_unit_pkg::ST_IDLE:
          if (go && op == `OP_LIT24 && !bad_dest)
            state <= exec_unit_pkg::ST_LIT;
          else if (go && op == `OP_MISC && sub == `SUB_SWAP)
            state <= exec_unit_pkg::ST_SWAP;
        exec_unit_pkg::ST_LIT:
          if (lit_valid)
            state <= exec_unit_pkg::ST_IDLE;
        exec_unit_pkg::ST_SWAP:
          if (mem_ack)
            state <= exec_unit_pkg::ST_IDLE;
        default:
          state <= exec_unit_pkg::ST_IDLE;
      endcase
  end

  // held context of a two-step operation
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lit_dest <= `D_X;
      lit_hi   <= 8'h00;
      swap_sel <= 2'b00;
    end
    else if (go)
    begin
      lit_dest <= sub;
      lit_hi   <= instr[7:0];
      swap_sel <= instr[6:5];
    end
  end

  // micro-instruction address; a write to it by literal wins over the step
  always_ff @(posedge clk)
  begin
    if (rst)
      fetch_addr <= `REG_RESET;
    else if (wr_en && wr_dest == `D_A)
      fetch_addr <= wr_val;
    else if (state == exec_unit_pkg::ST_LIT && lit_valid)
      fetch_addr <= next_inline + `ADDR_STEP; // [RULE_05]
    else if (go && op != `OP_LIT24)
      case (op)
        `OP_BR_FWD, `OP_CALL_FWD:
          fetch_addr <= next_inline + disp; // [RULE_13] [RULE_14]
        `OP_BR_BACK, `OP_CALL_REV:
          fetch_addr <= next_inline - disp; // [RULE_13] [RULE_14]
        default:
          fetch_addr <= next_inline;
      endcase
  end

  // stack traffic: calls push the next in-line address with its low four bits cleared
  assign stk_push = go && (op == `OP_CALL_FWD || op == `OP_CALL_REV); // [RULE_14]
  assign stk_load = wr_en && wr_dest == `D_TAS;
  assign stk_din  = stk_push ? {next_inline[23:4], 4'h0} : wr_val; // [RULE_15]

  return_addr_stack u_stack (
    .clk  (clk),
    .rst  (rst),
    .push (stk_push),
    .load (stk_load),
    .din  (stk_din),
    .top  (return_stack_top)
  );

  // register file; a field access adjust yields to a same-cycle count
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {x, y, t, l}                        <= {4{`REG_RESET}};
      {base_reg, limit_reg}               <= {2{`REG_RESET}};
      {field_addr_reg, field_descriptor_b} <= {2{`REG_RESET}};
      field_length_reg                    <= `REG_RESET;
      control_reg_pair                    <= 8'h00;
      maintenance_store_reg               <= `REG_RESET;
    end
    else
    begin
      if (fld_adj)
        {field_addr_reg, field_length_reg} <= field_count(field_addr_reg, field_length_reg,
          fld_variant, (fld_len == 5'h00) ? container_length : fld_len); // [RULE_01]
      if (wr_en)
        case (wr_dest)
          `D_X:   x                     <= wr_val;
          `D_Y:   y                     <= wr_val;
          `D_T:   t                     <= wr_val;
          `D_L:   l                     <= wr_val;
          `D_BR:  base_reg              <= wr_val;
          `D_LR:  limit_reg             <= wr_val;
          `D_FA:  field_addr_reg        <= wr_val;
          `D_FB:  field_descriptor_b    <= wr_val;
          `D_FL:  field_length_reg      <= wr_val;
          `D_CP:  control_reg_pair      <= wr_val[7:0];
          `D_MSM: maintenance_store_reg <= wr_val;
          default: ;
        endcase
      if (go && op == `OP_MISC)
        case (sub)
          `SUB_CLEAR:
          begin
            if (instr[0]) x <= `REG_RESET; // [RULE_18]
            if (instr[1]) y <= `REG_RESET;
            if (instr[2]) t <= `REG_RESET;
            if (instr[3]) l <= `REG_RESET;
            if (instr[4]) field_addr_reg <= `REG_RESET;
            if (instr[5]) field_descriptor_b <= `REG_RESET;
            if (instr[6]) field_length_reg <= `REG_RESET;
            if (instr[7]) base_reg <= `REG_RESET;
          end
          `SUB_SHIFT1:
          begin
            if (instr[7])
              y <= instr[5] ? rotl24(y, instr[6] ? 5'(6'd24 - xy_amt(instr[4:0],
                   control_reg_pair[`CPU_HI:`CPU_LO])) : 5'(xy_amt(instr[4:0],
                   control_reg_pair[`CPU_HI:`CPU_LO])))
                 : instr[6] ? y >> xy_amt(instr[4:0], control_reg_pair[`CPU_HI:`CPU_LO])
                 : y << xy_amt(instr[4:0], control_reg_pair[`CPU_HI:`CPU_LO]); // [RULE_19] [RULE_20]
            else
              x <= instr[5] ? rotl24(x, instr[6] ? 5'(6'd24 - xy_amt(instr[4:0],
                   control_reg_pair[`CPU_HI:`CPU_LO])) : 5'(xy_amt(instr[4:0],
                   control_reg_pair[`CPU_HI:`CPU_LO])))
                 : instr[6] ? x >> xy_amt(instr[4:0], control_reg_pair[`CPU_HI:`CPU_LO])
                 : x << xy_amt(instr[4:0], control_reg_pair[`CPU_HI:`CPU_LO]); // [RULE_19] [RULE_20]
          end
          `SUB_SHIFT2:
            {x, y} <= instr[5] ? rotl48({x, y}, instr[6] ? 6'(7'd48 - xy_amt(instr[4:0],
                        control_reg_pair[`CPU_HI:`CPU_LO])) : xy_amt(instr[4:0],
                        control_reg_pair[`CPU_HI:`CPU_LO]))
                    : instr[6] ? {x, y} >> xy_amt(instr[4:0], control_reg_pair[`CPU_HI:`CPU_LO])
                    : {x, y} << xy_amt(instr[4:0], control_reg_pair[`CPU_HI:`CPU_LO]); // [RULE_21]
          `SUB_COUNT:
            {field_addr_reg, field_length_reg} <= field_count(field_addr_reg, field_length_reg,
              instr[7:5], (instr[4:0] == 5'h00) ? container_length : instr[4:0]); // [RULE_22] [RULE_23]
          default: ;
        endcase
      if (state == exec_unit_pkg::ST_SWAP && mem_ack)
        case (swap_sel)
          2'b00:   x <= mem_rdata & mask24(mem_len); // [RULE_16]
          2'b01:   y <= mem_rdata & mask24(mem_len);
          2'b10:   t <= mem_rdata & mask24(mem_len);
          default: l <= mem_rdata & mask24(mem_len);
        endcase
    end
  end

  // swap request; write data cut to the field length before it leaves
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_req   <= 1'b0;
      mem_dir   <= 1'b0;
      mem_len   <= 5'h00;
      mem_addr  <= `REG_RESET;
      mem_wdata <= `REG_RESET;
    end
    else if (go && op == `OP_MISC && sub == `SUB_SWAP)
    begin
      mem_req   <= 1'b1;
      mem_dir   <= instr[7]; // [RULE_17]
      mem_len   <= swap_len;
      mem_addr  <= field_addr_reg;
      mem_wdata <= (instr[6:5] == 2'b00 ? x : instr[6:5] == 2'b01 ? y
                    : instr[6:5] == 2'b10 ? t : l) & mask24(swap_len); // [RULE_16]
    end
    else if (mem_ack)
      mem_req <= 1'b0;
  end

  // next-instruction OR strobe and refused-destination strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      m_or_valid <= 1'b0;
      m_or_data  <= 16'h0000;
      dest_error <= 1'b0;
    end
    else
    begin
      m_or_valid <= go && op == `OP_TSHIFT && sub == `D_M; // [RULE_09]
      m_or_data  <= wr_val[15:0];
      dest_error <= bad_dest;
    end
  end

  chk_lit8_zero_fill: assert property (@(posedge clk) disable iff (rst) // RULE_02
    go && op == `OP_LIT8 && sub == `D_X |=> x == {16'h0000, $past(instr[7:0])})
    else $error("8-bit literal not right-justified into x");

  chk_store_mode_gate: assert property (@(posedge clk) disable iff (rst) // RULE_04
    go && op == `OP_LIT8 && sub == `D_MSM && !cassette_mode
    |=> dest_error && $stable(maintenance_store_reg))
    else $error("maintenance store written outside cassette mode");

  chk_lit_word_addr: assert property (@(posedge clk) disable iff (rst) // RULE_06
    state == exec_unit_pkg::ST_LIT && lit_valid && lit_dest != `D_A
    |=> fetch_addr == $past(lit_addr) + 24'h000010)
    else $error("literal pair did not advance address by two words");

  chk_branch_target: assert property (@(posedge clk) disable iff (rst) // RULE_13
    go && op == `OP_BR_BACK
    |=> fetch_addr == $past(fetch_addr) + 24'h000010 - {8'h00, $past(instr[11:0]), 4'h0})
    else $error("backward branch target wrong");

  chk_call_push: assert property (@(posedge clk) disable iff (rst) // RULE_15
    go && op == `OP_CALL_FWD
    |=> return_stack_top == {$past(fetch_addr[23:4]) + 20'h00001, 4'h0})
    else $error("call pushed wrong return address");

  chk_length_floor: assert property (@(posedge clk) disable iff (rst || fld_adj) // RULE_23
    go && op == `OP_MISC && sub == `SUB_COUNT && instr[7:5] == 3'b110 && instr[4:0] != 5'h00
    && field_length_reg < {19'h00000, instr[4:0]} |=> field_length_reg == `REG_RESET)
    else $error("field length wrapped below zero");

  chk_clear_flag: assert property (@(posedge clk) disable iff (rst) // RULE_18
    go && op == `OP_MISC && sub == `SUB_CLEAR && instr[0] && !instr[1] |=> x == 24'h000000
    && y == $past(y))
    else $error("clear flags not honoured");

  chk_swap_release: assert property (@(posedge clk) disable iff (rst) // RULE_16
    mem_req && mem_ack |=> !mem_req && instr_ready)
    else $error("swap request not released after acknowledge");

  chk_m_or_strobe: assert property (@(posedge clk) disable iff (rst) // RULE_09
    go && op == `OP_TSHIFT && sub == `D_M |=> m_or_valid ##1 !m_or_valid)
    else $error("next-instruction OR strobe wrong");

endmodule // microinstruction_execute_unit

// File: test/main_mem_model.sv
// behavioural control store and main memory facing the execute unit
`timescale 1ns/100ps

module main_mem_model #(
  parameter logic [23:0] READ_VALUE = 24'hC3A5F7,
  parameter logic [15:0] LIT_MIX    = 16'h5A3C
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // second literal word
  input  wire logic [23:0] lit_addr,
  output logic             lit_valid,
  output logic      [15:0] lit_word,
  // swap port
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_wdata,
  input  wire logic [3:0]  ack_delay,
  output logic             mem_ack,
  output logic      [23:0] mem_rdata,
  output logic      [23:0] stored
);
  logic [3:0] wait_cnt;
  logic       busy;

  // word offered every other cycle so the unit must wait; off cycles carry junk
  always_ff @(posedge clk)
  begin
    lit_valid <= ~lit_valid & ~rst;
  end
  assign lit_word = (lit_addr[15:0] ^ LIT_MIX) ^ {16{~lit_valid}};

  // one ack after ack_delay idle cycles; read data is only good in the ack cycle
  always_ff @(posedge clk)
  begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst)
    begin
      busy      <= 1'b0;
      mem_rdata <= 24'h000000;
    end
    else if (mem_req && !busy)
    begin
      busy     <= 1'b1;
      wait_cnt <= ack_delay;
      stored   <= mem_wdata;
    end
    else if (busy && mem_ack)
      busy <= 1'b0;
    else if (busy && wait_cnt != 4'h0)
      wait_cnt <= wait_cnt - 4'h1;
    else if (busy)
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= READ_VALUE;
    end
  end
endmodule // main_mem_model

// File: test/testbench.sv
// self-checking bench for the micro-instruction execute unit
`timescale 1ns/100ps

module testbench;
  localparam logic [23:0] RV = 24'hC3A5F7;
  localparam logic [15:0] MIX = 16'h5A3C;
  localparam logic [7:0] FA_UP = 8'b00001010;
  localparam logic [7:0] FA_DN = 8'b10110000;
  localparam logic [7:0] FL_UP = 8'b00010100;
  localparam logic [7:0] FL_DN = 8'b11001000;
  logic        clk, rst, instr_valid, fld_adj, cassette_mode;
  logic [15:0] instr;
  logic [2:0]  fld_variant;
  logic [4:0]  fld_len;
  logic [3:0]  ack_delay;
  logic        instr_ready, lit_valid, mem_req, mem_dir, mem_ack, dest_error, m_or_valid;
  logic [15:0] lit_word, m_or_data, or_seen;
  logic [4:0]  mem_len;
  logic [7:0]  control_reg_pair;
  logic [23:0] fetch_addr, lit_addr, mem_addr, mem_wdata, mem_rdata, stored, x, y, t, l;
  logic [23:0] base_reg, limit_reg, field_addr_reg, field_descriptor_b, field_length_reg;
  logic [23:0] maintenance_store_reg, return_stack_top, exp_a, tv, fa, fl;
  logic [29:0] cap;
  int          fails, checks_done, cycles, errs;

  microinstruction_execute_unit i_microinstruction_execute_unit (
    .clk, .rst, .instr_valid, .instr, .instr_ready, .fetch_addr, .lit_valid, .lit_word,
    .lit_addr, .mem_req, .mem_dir, .mem_len, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .fld_adj, .fld_variant, .fld_len, .cassette_mode, .dest_error, .m_or_valid, .m_or_data,
    .x, .y, .t, .l, .base_reg, .limit_reg, .field_addr_reg, .field_descriptor_b,
    .field_length_reg, .control_reg_pair, .maintenance_store_reg, .return_stack_top
  );

  main_mem_model #(.READ_VALUE(RV), .LIT_MIX(MIX)) i_main_mem_model (
    .clk, .rst, .lit_addr, .lit_valid, .lit_word, .mem_req, .mem_wdata, .ack_delay,
    .mem_ack, .mem_rdata, .stored
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulses stand one cycle, so they are caught at the edge; also cuts a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (dest_error === 1'b1) errs++;
    if (m_or_valid === 1'b1) or_seen = m_or_data;
    if (mem_req === 1'b1) cap = {mem_dir, mem_len, mem_addr};
    if (cycles == 3000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  // register view by destination code; code D reads the captured next-instruction mask
  function automatic logic [23:0] rd(input logic [3:0] d);
    logic [23:0] v[14];
    v = '{x, y, t, l, fetch_addr, base_reg, limit_reg, field_addr_reg, field_descriptor_b,
          field_length_reg, return_stack_top, {16'h0000, control_reg_pair},
          maintenance_store_reg, {8'h00, or_seen}};
    return v[d];
  endfunction

  // one instruction through the ready handshake, then the expected sequencing
  task automatic op(input logic [15:0] ins);
    instr = ins;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    // one idle edge between requests, so strobes launched by this one are caught first
    @(negedge clk);
    for (int n = 0; n < 40 && instr_ready !== 1'b1; n++)
      @(negedge clk);
    case (ins[15:12])
      4'h9: exp_a = exp_a + 24'h000020;
      4'hC, 4'hE: exp_a = exp_a + 24'h000010 + {8'h00, ins[11:0], 4'h0};
      4'hD, 4'hF: exp_a = exp_a + 24'h000010 - {8'h00, ins[11:0], 4'h0};
      default: exp_a = exp_a + 24'h000010;
    endcase
    if (ins[15:8] == 8'h84)
      exp_a = {16'h0000, ins[7:0]};
    chk("fetch_addr", exp_a, fetch_addr);
  endtask

  // instruction followed by a look at one register
  task automatic opc(input logic [15:0] ins, input logic [3:0] d, input logic [23:0] e);
    op(ins);
    chk($sformatf("reg %h", d), e, rd(d));
  endtask

  initial
  begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = 16'h0000;
    fld_adj = 1'b0;
    fld_variant = 3'h0;
    fld_len = 5'h02;
    cassette_mode = 1'b0;
    ack_delay = 4'h0;
    exp_a = 24'h000000;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int d = 0; d < 13; d++)
      chk("reset", 24'h000000, rd(4'(d)));
    // every literal destination, address register included
    for (int d = 0; d < 12; d++)
      opc({4'h8, 4'(d), 4'hA, 4'(d)}, 4'(d), {16'h0000, 4'hA, 4'(d)});
    chk("refusals", 24'h000000, 24'(errs));
    opc(16'h8C55, 4'hC, 24'h000000);
    cassette_mode = 1'b1;
    opc(16'h8C55, 4'hC, 24'h000055);
    cassette_mode = 1'b0;
    tv = {8'h12, (exp_a[15:0] + 16'h0010) ^ MIX};
    opc(16'h9212, 4'h2, tv);
    fa = {8'h00, (exp_a[15:0] + 16'h0010) ^ MIX};
    opc(16'h9BEE, 4'hB, {16'h0000, fa[7:0]});
    op(16'h8B03);
    opc(16'hA004, 4'h0, tv << 4);
    opc(16'hA048, 4'h0, {tv[15:0], tv[23:16]});
    opc(16'hA100, 4'h1, tv << 3);
    fa = tv << 4;
    opc(16'hAD04, 4'hD, {8'h00, fa[15:0]});
    op(16'hAC04);
    opc(16'hAE04, 4'h2, tv);
    chk("refusals", 24'h000003, 24'(errs));
    opc({4'hB, 2'd0, 5'd24, 5'd8}, 4'h0, {16'h0000, tv[23:16]});
    opc({4'hB, 2'd1, 5'd4, 5'd0}, 4'h1, {21'h00000, tv[19:17]});
    op({4'hC, 12'h003});
    op({4'hD, 12'h002});
    fl = (exp_a + 24'h000010) & 24'hFFFFF0;
    opc({4'hE, 12'h001}, 4'hA, fl);
    fl = (exp_a + 24'h000010) & 24'hFFFFF0;
    opc({4'hF, 12'h000}, 4'hA, fl);
    // swap: prompt memory, then a slow one
    op(16'h80E5);
    opc({8'h02, 3'b100, 5'd0}, 4'h0, RV & 24'h000007);
    chk("swap dir len", 24'h000023, {18'h00000, cap[29:24]});
    chk("swap addr", 24'h0000A7, cap[23:0]);
    chk("stored", 24'h000005, stored);
    ack_delay = 4'h5;
    opc({8'h02, 3'b010, 5'd12}, 4'h2, RV & 24'h000FFF);
    chk("stored", tv & 24'h000FFF, stored);
    op(16'h81C3);
    opc(16'h0305, 4'h1, 24'h0000C3);
    chk("cleared", 24'h000000, x | t);
    opc(16'h0340, 4'h9, 24'h000000);
    op(16'h80F1);
    opc({8'h04, 3'b010, 5'd3}, 4'h0, 24'h00001E);
    opc({8'h04, 3'b100, 5'd0}, 4'h1, 24'h000186);
    op(16'h8B20);
    opc({8'h04, 3'b101, 5'd0}, 4'h1, 24'h001860);
    op(16'h8B60);
    opc({8'h04, 3'b000, 5'd0}, 4'h0, 24'h001E00);
    opc({8'h05, 3'b000, 5'd8}, 4'h0, 24'h1E0000);
    chk("y", 24'h186000, y);
    opc({8'h05, 3'b011, 5'd16}, 4'h0, 24'h60001E);
    chk("y", 24'h000018, y);
    op(16'h8707);
    op(16'h8905);
    op(16'h8B04);
    opc({8'h06, 3'b011, 5'd2}, 4'h7, 24'h000009);
    chk("fl", 24'h000003, field_length_reg);
    opc({8'h06, 3'b110, 5'd9}, 4'h9, 24'h000000);
    opc({8'h06, 3'b101, 5'd10}, 4'h7, 24'hFFFFFF);
    opc({8'h06, 3'b010, 5'd0}, 4'h9, 24'h000004);
    op(16'h8901);
    fa = 24'hFFFFFF;
    fl = 24'h000001;
    // every field-access variant in turn, step 2; the last one meets the length floor
    for (int v = 0; v < 8; v++)
    begin
      if (FA_UP[v]) fa = fa + 24'h000002;
      if (FA_DN[v]) fa = fa - 24'h000002;
      if (FL_UP[v]) fl = fl + 24'h000002;
      if (FL_DN[v]) fl = (fl < 24'h000002) ? 24'h000000 : fl - 24'h000002;
      fld_variant = 3'(v);
      fld_adj = 1'b1;
      @(negedge clk);
      fld_adj = 1'b0;
      @(negedge clk);
      chk("fa adj", fa, field_addr_reg);
      chk("fl adj", fl, field_length_reg);
    end
    summarize();
  end
endmodule // testbench
